//--- hw/morf_regs.svh
// register offsets, field positions and reset values of the operational register file
// assumes inclusion by bare name from every design file that decodes registers
`ifndef MORF_REGS_SVH
`define MORF_REGS_SVH
// data space offsets
`define MORF_A_IND   6'h00
`define MORF_A_TMR   6'h01
`define MORF_A_PC    6'h02
`define MORF_A_STAT  6'h03
`define MORF_A_RSEL  6'h04
`define MORF_A_PA    6'h05
`define MORF_A_PB    6'h06
`define MORF_A_IRQF  6'h0F
`define MORF_A_GPR0  6'h10
`define MORF_A_GPRN  6'h2F
// control space offsets
`define MORF_A_PDN   6'h0B
`define MORF_A_ODC   6'h0C
`define MORF_A_PHC   6'h0D
`define MORF_A_WDC   6'h0E
// ctrl_reg fields
`define MORF_CT_GIE  6
`define MORF_CT_TS   5
`define MORF_CT_TE   4
`define MORF_CT_PAB  3
// status_flags fields
`define MORF_ST_WAKE 7
`define MORF_ST_TO   4
`define MORF_ST_PD   3
`define MORF_ST_WMSK 8'h67
`define MORF_ST_RST  8'h18
// fixed read bits
`define MORF_RSEL_HI 2'h3
`define MORF_PDN_ONE 8'h88
`define MORF_ODC_MSK 8'hF7
`define MORF_PHC_ONE 8'h08
`define MORF_WDC_MSK 8'hC0
`define MORF_MSK_ONE 5'h1F
// port b pins with a role
`define MORF_PB_TMR  2
`define MORF_PB_INP  3
// instruction cycle divider end counts
`define MORF_DIV2_END 2'h1
`define MORF_DIV4_END 2'h3
`endif

//--- hw/morf_pkg.sv
// types shared by the operational register file and its prescaler
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package morf_pkg;
  // operation announced by the core for the current instruction cycle
  typedef enum logic [3:0] {
    MORF_OP_STEP  = 4'h0,
    MORF_OP_JMP   = 4'h1,
    MORF_OP_CALL  = 4'h2,
    MORF_OP_RET   = 4'h3,
    MORF_OP_LITERAL_EXIT_OP  = 4'h4,
    MORF_OP_IRQ_EXIT_OP  = 4'h5,
    MORF_OP_SLEEP = 4'h6,
    MORF_OP_WATCHDOG_CLEAR_OP  = 4'h7,
    MORF_OP_ENI   = 4'h8,
    MORF_OP_GLOBAL_IRQ_OFF  = 4'h9,
    MORF_OP_IRQ   = 4'hA
  } morf_op_t;
  // sequencing state, one-hot
  typedef enum logic [2:0] {
    MORF_EXEC  = 3'h1,
    MORF_FLUSH = 3'h2,
    MORF_SLEEP = 3'h4
  } morf_fsm_t;
endpackage
`default_nettype wire

//--- hw/morf_pscale_if.sv
// signals between the register file and the shared prescaler
// assumes both ends run on the same clock
`default_nettype none
interface morf_pscale_if;
  logic       tick;
  logic       clr;
  logic [2:0] sel;
  logic       to_wdt;
  logic       tick_out;
  modport owner  (output tick, output clr, output sel, output to_wdt, input tick_out);
  modport scaler (input tick, input clr, input sel, input to_wdt, output tick_out);
endinterface
`default_nettype wire

//--- hw/morf_prescaler.sv
// shared 8-bit prescaler, timer or watchdog ratio
// assumes tick and clr are one-cycle pulses on sys_clk
`default_nettype none
module morf_prescaler
  import morf_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     nrst,
  morf_pscale_if.scaler ps
);
  typedef struct packed {
    logic [7:0] cnt;
  } morf_ps_st_t;

  morf_ps_st_t q;
  morf_ps_st_t d;
  logic [8:0]  span;
  logic [7:0]  mask;

  // divide by 2^(n+1) for the timer, 2^n for the watchdog
  // ratio mask select
  always_comb
  begin
    span = (9'h002 << ps.sel) - 9'h001;
    mask = ps.to_wdt ? span[8:1] : span[7:0];
    ps.tick_out = ps.tick && ((q.cnt & mask) == mask);
    d = q;
    if (ps.clr)
      d.cnt = 8'h00;
    else if (ps.tick)
      d.cnt = q.cnt + 8'h01;
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end
endmodule
`default_nettype wire

//--- hw/morf_regfile.sv
// operational and special function registers of a small 8-bit controller
// assumes the core presents one access and one operation per instruction cycle
// and holds them while core_busy is high
//
// Overview of operation
// - address zero reaches the ram_select target
// - timer counts cycles or selected pin edges
// - prescaler serves timer or watchdog, never both
// - timer write clears timer-assigned prescaler
// - ten-bit counter and stack, cleared on reset
// - direct_branch loads ten-bit target
// - subroutine_branch pushes next address, loads target
// - returns load counter from stack top
// - data writes to counter clear bits 8-9
// - counter-changing instructions take one extra cycle
// - wake cause reads 1 after pin-change wake
// - timeout and power-down flags follow sleep/clear/timeout
// - ram_select top bits read one, ignore writes
// - port a four bits; port b pin3 input only
// - falling edge sets ext_irq_flag until cleared
// - port b input change sets pin_change_flag
// - timer overflow sets flag; upper bits zero
// - software only clears flags; read masked
// - global enable cleared by off/entry, set by on/exit
// - prescale ratio 2^(n+1) timer, 2^n watchdog
// - direction bit 0 drives, 1 floats pin
// - pull-down bits active low; spare bits one
// - request only for enabled flags
`default_nettype none
`include "morf_regs.svh"
module morf_regfile
  import morf_pkg::*;
#(
  parameter int        STK_DEPTH = 2,
  parameter logic [9:0] IRQ_VEC  = 10'h008,
  parameter int        NGPR      = 32
)(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       clk_div4,
  output logic            cyc_en,
  output logic            core_busy,
  input  wire logic       op_valid,
  input  wire morf_op_t   op_code,
  input  wire logic [9:0] op_target,
  input  wire logic [5:0] acc_addr,
  input  wire logic       acc_io,
  input  wire logic       acc_ctrl,
  input  wire logic       acc_wr,
  input  wire logic [7:0] acc_wdata,
  output logic [7:0]      acc_rdata,
  input  wire logic       alu_flag_we,
  input  wire logic [2:0] alu_flags,
  output logic [9:0]      pc,
  output logic            irq_req,
  input  wire logic       wdt_tick_in,
  output logic            wdt_tick_out,
  input  wire logic       wdt_timeout,
  input  wire logic       ext_irq_pin,
  input  wire logic [3:0] pa_in,
  output logic [3:0]      pa_out,
  output logic [3:0]      pa_oe,
  input  wire logic [7:0] pb_in,
  output logic [7:0]      pb_out,
  output logic [7:0]      pb_oe,
  output logic [2:0]      pa_pd_en,
  output logic [2:0]      pb_pd_en,
  output logic [7:0]      od_ctrl,
  output logic [7:0]      ph_ctrl,
  output logic [7:0]      wdt_ctrl
);
  typedef struct packed {
    logic [1:0]                 div;
    morf_fsm_t                  fsm;
    logic [9:0]                 pc;
    logic [STK_DEPTH-1:0][9:0]  stk;
    logic [7:0]                 tmr;
    logic [7:0]                 status;
    logic [5:0]                 rsel;
    logic [3:0]                 pa_dat;
    logic [3:0]                 pa_dir;
    logic [7:0]                 pb_dat;
    logic [7:0]                 pb_dir;
    logic [7:0]                 pdn;
    logic [7:0]                 odc;
    logic [7:0]                 phc;
    logic [7:0]                 wdc;
    logic [7:0]                 ctrl;
    logic [2:0]                 flags;
    logic [2:0]                 mask;
    logic [NGPR-1:0][7:0]       gpr;
    logic [7:0]                 rdata;
    logic [3:0]                 pa_s1;
    logic [3:0]                 pa_s2;
    logic [7:0]                 pb_s1;
    logic [7:0]                 pb_s2;
    logic [7:0]                 pb_prev;
    logic                       ex_s1;
    logic                       ex_s2;
    logic                       ex_prev;
  } morf_st_t;

  morf_st_t      q;
  morf_st_t      d;
  morf_pscale_if ps ();
  logic          exec;
  logic          raw_tick;
  logic          tmr_tick;
  logic          tmr_wr;
  logic          branch;
  logic          ex_fall;
  logic          pb_chg;
  logic [5:0]    ea;
  logic [9:0]    pc_next;
  logic [2:0]    set_f;
  logic [7:0]    pa_rd;
  logic [7:0]    pb_rd;

  // shared prescaler
  morf_prescaler u_pscale (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ps      (ps)
  );

  assign ea = (acc_addr == `MORF_A_IND) ? q.rsel : acc_addr;

  // pins read back as pins where floating, as latches where driven
  assign pa_rd = {4'h0, (q.pa_dir & q.pa_s2) | (~q.pa_dir & q.pa_dat)};
  assign pb_rd = (q.pb_dir & q.pb_s2) | (~q.pb_dir & q.pb_dat);

  // data space read value; the indirect port itself reads zero
  function automatic logic [7:0] rd_data(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= `MORF_A_GPR0 && a <= `MORF_A_GPRN)
      v = q.gpr[a[4:0]];
    else
      unique case (a)
        `MORF_A_TMR:  v = q.tmr;
        `MORF_A_PC:   v = q.pc[7:0];
        `MORF_A_STAT: v = q.status;
        `MORF_A_RSEL: v = {`MORF_RSEL_HI, q.rsel};
        `MORF_A_PA:   v = pa_rd;
        `MORF_A_PB:   v = pb_rd;
        `MORF_A_IRQF: v = {5'h00, q.flags & q.mask};
        default:      v = 8'h00;
      endcase
    return v;
  endfunction

  // control space read value
  function automatic logic [7:0] rd_ctl(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `MORF_A_PA:   v = {4'h0, q.pa_dir};
      `MORF_A_PB:   v = q.pb_dir;
      `MORF_A_PDN:  v = q.pdn | `MORF_PDN_ONE;
      `MORF_A_ODC:  v = q.odc & `MORF_ODC_MSK;
      `MORF_A_PHC:  v = q.phc | `MORF_PHC_ONE;
      `MORF_A_WDC:  v = q.wdc & `MORF_WDC_MSK;
      `MORF_A_IRQF: v = {`MORF_MSK_ONE, q.mask};
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  // event sources seen through the second synchroniser stage only
  always_comb
  begin
    exec    = cyc_en && q.fsm == MORF_EXEC;
    ex_fall = q.ex_prev && !q.ex_s2;
    pb_chg  = |((q.pb_s2 ^ q.pb_prev) & q.pb_dir);
    // cycle clock or chosen pin edge
    if (q.ctrl[`MORF_CT_TS])
      raw_tick = q.ctrl[`MORF_CT_TE]
               ? (q.pb_prev[`MORF_PB_TMR] && !q.pb_s2[`MORF_PB_TMR])
               : (!q.pb_prev[`MORF_PB_TMR] && q.pb_s2[`MORF_PB_TMR]);
    else
      raw_tick = cyc_en;
    tmr_wr = exec && acc_wr && !acc_io && !acc_ctrl && ea == `MORF_A_TMR;
  end

  // prescaler steering
  always_comb
  begin
    ps.to_wdt = q.ctrl[`MORF_CT_PAB];
    ps.sel    = q.ctrl[2:0];
    ps.tick   = ps.to_wdt ? wdt_tick_in : raw_tick;
    ps.clr    = ps.to_wdt
              ? (exec && op_valid && (op_code == MORF_OP_WATCHDOG_CLEAR_OP || op_code == MORF_OP_SLEEP))
              : tmr_wr;
    tmr_tick     = ps.to_wdt ? raw_tick : ps.tick_out;
    wdt_tick_out = ps.to_wdt ? ps.tick_out : wdt_tick_in;
  end

  // next state
  always_comb
  begin
    d       = q;
    branch  = 1'b0;
    pc_next = q.pc + 10'h001;
    set_f   = 3'h0;
    // synchronisers
    d.pa_s1   = pa_in;
    d.pa_s2   = q.pa_s1;
    d.pb_s1   = pb_in;
    d.pb_s2   = q.pb_s1;
    d.pb_prev = q.pb_s2;
    d.ex_s1   = ext_irq_pin;
    d.ex_s2   = q.ex_s1;
    d.ex_prev = q.ex_s2;
    // instruction cycle divider
    if (q.div == (clk_div4 ? `MORF_DIV4_END : `MORF_DIV2_END))
      d.div = 2'h0;
    else
      d.div = q.div + 2'h1;
    if (tmr_tick)
      d.tmr = q.tmr + 8'h01;
    set_f[0] = tmr_tick && q.tmr == 8'hFF && !tmr_wr;
    set_f[1] = pb_chg;
    set_f[2] = ex_fall;
    if (alu_flag_we && exec)
      d.status[2:0] = alu_flags;
    if (wdt_timeout)
      d.status[`MORF_ST_TO] = 1'b0;
    unique case (q.fsm)
      MORF_EXEC:
      begin
        if (cyc_en && op_valid)
        begin
          unique case (op_code)
            MORF_OP_JMP:
            begin
              pc_next = op_target;
              branch  = 1'b1;
            end
            MORF_OP_CALL:
            begin
              d.stk   = {q.stk[STK_DEPTH-2:0], pc_next};
              pc_next = op_target;
              branch  = 1'b1;
            end
            MORF_OP_RET, MORF_OP_LITERAL_EXIT_OP, MORF_OP_IRQ_EXIT_OP:
            begin
              pc_next = q.stk[0];
              d.stk   = {q.stk[0], q.stk[STK_DEPTH-1:1]};
              branch  = 1'b1;
              if (op_code == MORF_OP_IRQ_EXIT_OP)
                d.ctrl[`MORF_CT_GIE] = 1'b1;
            end
            MORF_OP_SLEEP:
            begin
              d.status[`MORF_ST_TO] = 1'b1;
              d.status[`MORF_ST_PD] = 1'b0;
            end
            MORF_OP_WATCHDOG_CLEAR_OP:
            begin
              d.status[`MORF_ST_TO] = 1'b1;
              d.status[`MORF_ST_PD] = 1'b1;
            end
            MORF_OP_ENI:  d.ctrl[`MORF_CT_GIE] = 1'b1;
            MORF_OP_GLOBAL_IRQ_OFF: d.ctrl[`MORF_CT_GIE] = 1'b0;
            MORF_OP_IRQ:
            begin
              d.stk   = {q.stk[STK_DEPTH-2:0], q.pc};
              pc_next = IRQ_VEC;
              branch  = 1'b1;
              d.ctrl[`MORF_CT_GIE] = 1'b0;
            end
            default: ;
          endcase
        end
        // register writes
        if (exec && acc_wr)
        begin
          if (acc_ctrl)
            d.ctrl = acc_wdata;
          else if (acc_io)
            unique case (acc_addr)
              `MORF_A_PA:   d.pa_dir = acc_wdata[3:0];
              `MORF_A_PB:   d.pb_dir = acc_wdata;
              `MORF_A_PDN:  d.pdn    = acc_wdata;
              `MORF_A_ODC:  d.odc    = acc_wdata;
              `MORF_A_PHC:  d.phc    = acc_wdata;
              `MORF_A_WDC:  d.wdc    = acc_wdata;
              `MORF_A_IRQF: d.mask   = acc_wdata[2:0];
              default: ;
            endcase
          else if (ea >= `MORF_A_GPR0 && ea <= `MORF_A_GPRN)
            d.gpr[ea[4:0]] = acc_wdata;
          else
            unique case (ea)
              `MORF_A_TMR:  d.tmr = acc_wdata;
              `MORF_A_PC:
              begin
                pc_next = {2'h0, acc_wdata};
                branch  = 1'b1;
              end
              `MORF_A_STAT:
                d.status = (q.status & ~`MORF_ST_WMSK) | (acc_wdata & `MORF_ST_WMSK);
              `MORF_A_RSEL: d.rsel   = acc_wdata[5:0];
              `MORF_A_PA:   d.pa_dat = acc_wdata[3:0];
              `MORF_A_PB:   d.pb_dat = acc_wdata;
              `MORF_A_IRQF: d.flags  = q.flags & acc_wdata[2:0];
              default: ;
            endcase
        end
        if (cyc_en)
          d.pc = pc_next;
        if (exec && branch)
          d.fsm = MORF_FLUSH;
        else if (exec && op_valid && op_code == MORF_OP_SLEEP)
          d.fsm = MORF_SLEEP;
      end
      MORF_FLUSH:
      begin
        if (cyc_en)
          d.fsm = MORF_EXEC;
      end
      MORF_SLEEP:
      begin
        if (pb_chg)
        begin
          d.status[`MORF_ST_WAKE] = 1'b1;
          d.fsm = MORF_EXEC;
        end
        else if (wdt_timeout)
          d.fsm = MORF_EXEC;
      end
      default: d.fsm = MORF_EXEC;
    endcase
    d.flags = d.flags | set_f;
    // registered read answer
    d.rdata = acc_ctrl ? q.ctrl : (acc_io ? rd_ctl(acc_addr) : rd_data(ea));
  end

  // state register; power reset sets timeout and power-down flags
  // other state cleared on reset, fsm set to MORF_EXEC
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      q        <= '0;
      q.fsm    <= MORF_EXEC;
      q.status <= `MORF_ST_RST;
    end
    else
      q <= d;
  end

  // outputs
  always_comb
  begin
    cyc_en    = q.div == (clk_div4 ? `MORF_DIV4_END : `MORF_DIV2_END);
    core_busy = q.fsm != MORF_EXEC;
    acc_rdata = q.rdata;
    pc        = q.pc;
    irq_req   = q.ctrl[`MORF_CT_GIE] && |(q.flags & q.mask);
    pa_out    = q.pa_dat;
    pa_oe     = ~q.pa_dir;
    pb_out    = q.pb_dat;
    pb_oe     = ~q.pb_dir;
    pb_oe[`MORF_PB_INP] = 1'b0;
    if (q.ctrl[`MORF_CT_TS])
      pb_oe[`MORF_PB_TMR] = 1'b0;
    pa_pd_en  = ~q.pdn[2:0];
    pb_pd_en  = ~q.pdn[6:4];
    od_ctrl   = q.odc & `MORF_ODC_MSK;
    ph_ctrl   = q.phc | `MORF_PHC_ONE;
    wdt_ctrl  = q.wdc & `MORF_WDC_MSK;
  end
endmodule
`default_nettype wire

//--- tb/morf_regfile_sva.sv
// assertion checker for the operational register file, watching its ports only
// assumes one clock sys_clk and a synchronous active-low nrst
`default_nettype none
module morf_regfile_chk
  import morf_pkg::*;
#(
  parameter logic [9:0] IRQ_VEC = 10'h008
)(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       cyc_en,
  input wire logic       core_busy,
  input wire logic       op_valid,
  input wire morf_op_t   op_code,
  input wire logic [9:0] op_target,
  input wire logic [5:0] acc_addr,
  input wire logic       acc_io,
  input wire logic       acc_ctrl,
  input wire logic       acc_wr,
  input wire logic [7:0] acc_rdata,
  input wire logic [9:0] pc,
  input wire logic       irq_req,
  input wire logic [7:0] pb_oe
);
  logic op_go;
  logic dsp;
  // an operation is taken at a cycle edge while the core is not held off
  assign op_go = cyc_en && op_valid && !core_busy;
  assign dsp = !acc_io && !acc_ctrl;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  pc_reset_a: assert property (disable iff (1'b0) !nrst |=> pc == 10'h000)
    else $error("pc not cleared by reset");
  jmp_load_a: assert property (op_go && op_code == MORF_OP_JMP |=> pc == $past(op_target))
    else $error("jump target not loaded");
  call_load_a: assert property (op_go && op_code == MORF_OP_CALL |=>
    pc == $past(op_target) && core_busy) else $error("call target not loaded");
  flush_len_a: assert property (op_go && op_code inside {MORF_OP_JMP, MORF_OP_RET}
    |=> core_busy ##[0:3] (cyc_en ##1 !core_busy)) else $error("branch stall length wrong");
  step_inc_a: assert property (op_go && op_code == MORF_OP_STEP && !acc_wr
    |=> pc == $past(pc) + 10'h001 && !core_busy) else $error("plain step wrong");
  pcwr_clr_a: assert property (cyc_en && !core_busy && !op_valid && acc_wr && dsp
    && acc_addr == 6'h02 |=> pc[9:8] == 2'h0) else $error("pc upper bits kept");
  irq_entry_a: assert property (op_go && op_code == MORF_OP_IRQ |=>
    pc == IRQ_VEC && !irq_req) else $error("interrupt entry wrong");
  global_irq_off_off_a: assert property (op_go && op_code == MORF_OP_GLOBAL_IRQ_OFF |=> !irq_req)
    else $error("request after global off");
  rsel_hi_a: assert property (dsp && acc_addr == 6'h04 |=> acc_rdata[7:6] == 2'h3)
    else $error("ram select top bits not one");
  irqf_hi_a: assert property (dsp && acc_addr == 6'h0F |=> acc_rdata[7:3] == 5'h00)
    else $error("flag upper bits not zero");
  pin3_in_a: assert property (pb_oe[3] == 1'b0)
    else $error("input-only pin driven");
endmodule
bind morf_regfile morf_regfile_chk #(.IRQ_VEC(IRQ_VEC)) chk_u (
  .sys_clk(sys_clk), .nrst(nrst), .cyc_en(cyc_en), .core_busy(core_busy),
  .op_valid(op_valid), .op_code(op_code), .op_target(op_target), .acc_addr(acc_addr),
  .acc_io(acc_io), .acc_ctrl(acc_ctrl), .acc_wr(acc_wr), .acc_rdata(acc_rdata),
  .pc(pc), .irq_req(irq_req), .pb_oe(pb_oe)
);
`default_nettype wire

//--- tb/morf_core_model.sv
// behavioural instruction core: one operation and one access per instruction cycle
// assumes its caller resumes 1 ns after a rising edge of sys_clk
`default_nettype none
module morf_core_model
  import morf_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       cyc_en,
  input  wire logic       core_busy,
  input  wire logic [7:0] acc_rdata,
  output var logic        op_valid,
  output var morf_op_t    op_code,
  output var logic [9:0]  op_target,
  output var logic [5:0]  acc_addr,
  output var logic        acc_io,
  output var logic        acc_ctrl,
  output var logic        acc_wr,
  output var logic [7:0]  acc_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial
  begin
    op_valid = 1'b0;
    op_code = MORF_OP_STEP;
    op_target = 10'h000;
    acc_addr = 6'h3F;
    acc_io = 1'b0;
    acc_ctrl = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = 8'h00;
  end
  // hold a request until the edge that takes it, then release for one edge
  task automatic issue(input morf_op_t op, input logic v, input logic [9:0] tgt,
                       input logic [5:0] a, input logic io, input logic ct,
                       input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    op_valid = v;
    op_code = op;
    op_target = tgt;
    acc_addr = a;
    acc_io = io;
    acc_ctrl = ct;
    acc_wr = wr;
    acc_wdata = wd;
    while (!(cyc_en && !core_busy) && n < 40)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    op_valid = 1'b0;
    acc_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // read data is registered one edge after the address
  task automatic rd(input logic [5:0] a, input logic io, output logic [7:0] d);
    acc_addr = a;
    acc_io = io;
    acc_ctrl = 1'b0;
    @(posedge sys_clk);
    #1;
    d = acc_rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the operational register file
// assumes the core model drives the operation and access ports
`default_nettype none
module tb_top;
  import morf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, nrst, cyc_en, core_busy, op_valid, acc_io, acc_ctrl, acc_wr, irq_req;
  logic wdt_tick_in, wdt_tick_out, wdt_timeout, ext_irq_pin, clk_div4;
  morf_op_t op_code;
  logic [9:0] op_target, pc;
  logic [5:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, pb_in, pb_out, pb_oe, od_ctrl, ph_ctrl, wdt_ctrl;
  logic [3:0] pa_in, pa_out, pa_oe;
  logic [2:0] pa_pd_en, pb_pd_en;
  int error_cnt, n_checks, tick_cnt;
  morf_regfile dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .clk_div4(clk_div4), .cyc_en(cyc_en),
    .core_busy(core_busy), .op_valid(op_valid), .op_code(op_code), .op_target(op_target),
    .acc_addr(acc_addr), .acc_io(acc_io), .acc_ctrl(acc_ctrl), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .alu_flag_we(1'b0), .alu_flags(3'h0),
    .pc(pc), .irq_req(irq_req), .wdt_tick_in(wdt_tick_in), .wdt_tick_out(wdt_tick_out),
    .wdt_timeout(wdt_timeout), .ext_irq_pin(ext_irq_pin), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .pa_pd_en(pa_pd_en),
    .pb_pd_en(pb_pd_en), .od_ctrl(od_ctrl), .ph_ctrl(ph_ctrl), .wdt_ctrl(wdt_ctrl));
  morf_core_model core_u (
    .sys_clk(sys_clk), .cyc_en(cyc_en), .core_busy(core_busy), .acc_rdata(acc_rdata),
    .op_valid(op_valid), .op_code(op_code), .op_target(op_target), .acc_addr(acc_addr),
    .acc_io(acc_io), .acc_ctrl(acc_ctrl), .acc_wr(acc_wr), .acc_wdata(acc_wdata));
  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // count watchdog ticks leaving on wdt_tick_out
  always @(posedge sys_clk)
    if (wdt_tick_out === 1'b1)
      tick_cnt++;
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic io, input logic [7:0] d);
    core_u.issue(MORF_OP_STEP, 1'b0, 10'h000, a, io, 1'b0, 1'b1, d);
  endtask
  task automatic wctl(input logic [7:0] d);
    core_u.issue(MORF_OP_STEP, 1'b0, 10'h000, 6'h00, 1'b0, 1'b1, 1'b1, d);
  endtask
  task automatic op(input morf_op_t o, input logic [9:0] t);
    core_u.issue(o, 1'b1, t, 6'h3F, 1'b0, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic rdc(input logic [5:0] a, input logic io, input logic [7:0] exp);
    logic [7:0] d;
    core_u.rd(a, io, d);
    chk(d, exp);
  endtask
  task automatic t_reset;
    chk(pc, 10'h000);
    rdc(6'h03, 1'b0, 8'h18);
    rdc(6'h04, 1'b0, 8'hC0);
    rdc(6'h0B, 1'b1, 8'h88);
  endtask
  task automatic t_regs;
    wr(6'h04, 1'b0, 8'h12);
    rdc(6'h04, 1'b0, 8'hD2);
    wr(6'h04, 1'b0, 8'h10);
    wr(6'h00, 1'b0, 8'hA5);
    rdc(6'h10, 1'b0, 8'hA5);
    wr(6'h05, 1'b0, 8'hFF);
    rdc(6'h05, 1'b0, 8'h0F);
    wr(6'h05, 1'b1, 8'hF5);
    chk(pa_oe, 4'hA);
    wr(6'h0B, 1'b1, 8'h47);
    rdc(6'h0B, 1'b1, 8'hCF);
    chk({pb_pd_en, pa_pd_en}, 6'h18);
  endtask
  task automatic t_branch;
    morf_op_t rets[2];
    rets = '{MORF_OP_LITERAL_EXIT_OP, MORF_OP_IRQ_EXIT_OP};
    op(MORF_OP_JMP, 10'h200);
    chk(pc, 10'h200);
    chk(core_busy, 1'b1);
    op(MORF_OP_CALL, 10'h123);
    chk(pc, 10'h123);
    op(MORF_OP_RET, 10'h000);
    chk(pc, 10'h201);
    for (int i = 0; i < 2; i++)
    begin
      op(MORF_OP_CALL, 10'h040);
      op(rets[i], 10'h000);
      chk(pc, 10'h202 + 10'(i));
    end
    wr(6'h02, 1'b0, 8'h55);
    chk(pc, 10'h055);
  endtask
  task automatic t_timer;
    wctl(8'h00);
    wr(6'h0F, 1'b1, 8'h07);
    wr(6'h01, 1'b0, 8'hFF);
    wt(20);
    rdc(6'h0F, 1'b0, 8'h01);
    wr(6'h0F, 1'b0, 8'h00);
    rdc(6'h0F, 1'b0, 8'h00);
    wr(6'h0F, 1'b0, 8'hFF);
    rdc(6'h0F, 1'b0, 8'h00);
  endtask
  task automatic pulses(input logic [7:0] c, input int exp);
    wctl(c);
    op(MORF_OP_WATCHDOG_CLEAR_OP, 10'h000);
    tick_cnt = 0;
    repeat (4)
    begin
      wdt_tick_in = 1'b1;
      wt(1);
      wdt_tick_in = 1'b0;
      wt(1);
    end
    chk(tick_cnt, exp);
  endtask
  task automatic t_irq;
    wr(6'h06, 1'b1, 8'hFF);
    wr(6'h0F, 1'b1, 8'h06);
    ext_irq_pin = 1'b0;
    wt(8);
    rdc(6'h0F, 1'b0, 8'h04);
    ext_irq_pin = 1'b1;
    pb_in[5] = ~pb_in[5];
    wt(8);
    rdc(6'h0F, 1'b0, 8'h06);
    wr(6'h0F, 1'b1, 8'h02);
    rdc(6'h0F, 1'b0, 8'h02);
    op(MORF_OP_ENI, 10'h000);
    chk(irq_req, 1'b1);
    wr(6'h0F, 1'b1, 8'h00);
    chk(irq_req, 1'b0);
    wr(6'h0F, 1'b1, 8'h02);
    op(MORF_OP_GLOBAL_IRQ_OFF, 10'h000);
    chk(irq_req, 1'b0);
    op(MORF_OP_ENI, 10'h000);
    op(MORF_OP_IRQ, 10'h000);
    chk(pc, 10'h008);
    op(MORF_OP_IRQ_EXIT_OP, 10'h000);
    chk(irq_req, 1'b1);
  endtask
  task automatic t_sleep;
    op(MORF_OP_WATCHDOG_CLEAR_OP, 10'h000);
    rdc(6'h03, 1'b0, 8'h18);
    op(MORF_OP_SLEEP, 10'h000);
    rdc(6'h03, 1'b0, 8'h10);
    wdt_timeout = 1'b1;
    wt(1);
    wdt_timeout = 1'b0;
    wt(6);
    rdc(6'h03, 1'b0, 8'h00);
    chk(core_busy, 1'b0);
    op(MORF_OP_SLEEP, 10'h000);
    pb_in[6] = ~pb_in[6];
    wt(8);
    rdc(6'h03, 1'b0, 8'h90);
  endtask
  // timer clocked by rising edges on the timer pin, prescaled by two
  task automatic t_pin;
    wctl(8'h20);
    wr(6'h06, 1'b1, 8'h00);
    chk(pb_oe, 8'hF3);
    wr(6'h01, 1'b0, 8'h00);
    repeat (4)
    begin
      pb_in[2] = ~pb_in[2];
      wt(4);
    end
    rdc(6'h01, 1'b0, 8'h01);
  endtask
  // second reset in mid-run with a four-clock instruction cycle
  task automatic t_div4;
    clk_div4 = 1'b1;
    nrst = 1'b0;
    wt(2);
    nrst = 1'b1;
    chk(pc, 10'h000);
    wt(3);
    chk(cyc_en, 1'b1);
    op(MORF_OP_STEP, 10'h000);
    chk(pc, 10'h001);
    op(MORF_OP_JMP, 10'h3C0);
    chk(pc, 10'h3C0);
    chk(core_busy, 1'b1);
    wt(3);
    chk(core_busy, 1'b0);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  // reset, then the scenarios in order
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    tick_cnt = 0;
    nrst = 1'b0;
    wdt_tick_in = 1'b0;
    wdt_timeout = 1'b0;
    ext_irq_pin = 1'b1;
    clk_div4 = 1'b0;
    pa_in = 4'h0;
    pb_in = 8'h00;
    wt(2);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_branch();
    t_timer();
    pulses(8'h08, 4);
    pulses(8'h09, 2);
    pulses(8'h00, 4);
    t_irq();
    t_sleep();
    t_pin();
    t_div4();
    wrap_up();
  end
endmodule
`default_nettype wire
